/* src/usdc_defines.svh */
// offsets, field layout, reset values and counts of the descriptor string config slice
// assumes: included by bare name from the design modules
`ifndef USDC_DEFINES_SVH
`define USDC_DEFINES_SVH

// register offsets, byte addressed, 8-bit registers
`define USDC_UID_FIRST 8'h10
`define USDC_UID_LAST 8'h1f
`define USDC_LANG_LOW_OFS 8'h20
`define USDC_LANG_HIGH_OFS 8'h21
`define USDC_SER_LEN_OFS 8'h22
`define USDC_MAKER_LEN_OFS 8'h23

// reset values
`define USDC_LANG_LOW_RST 8'h09
`define USDC_LANG_HIGH_RST 8'h04
`define USDC_SER_LEN_RST 6'h18
`define USDC_MAKER_LEN_RST 7'h00

// field widths
`define USDC_SER_LEN_W 6
`define USDC_MAKER_LEN_W 7

// string descriptor indices
`define USDC_IDX_LANG 8'h00
`define USDC_IDX_SERIAL 8'h01
`define USDC_IDX_MAKER 8'h03

// unique id formatting: version nibble in byte 6, variant bits in byte 8
`define USDC_UID_VER_BYTE 6
`define USDC_UID_VER_NIB 4'h4
`define USDC_UID_VAR_BYTE 8
`define USDC_UID_VAR_BITS 2'h2

// cycles of mixing before the unique id freezes
`define USDC_UID_SPIN 8'h80

`endif

/* src/usdc_pkg.sv */
// types shared by the descriptor string config slice
// assumes: nothing beyond the defines header
package usdc_pkg;
  // configuration write/read request from eeprom loader or smbus slave
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } usdc_cfg_req_t;

  // configuration read answer
  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
  } usdc_cfg_rsp_t;

  // string descriptor query from the hub's control endpoint
  typedef struct packed {
    logic valid;
    logic [7:0] index;
  } usdc_desc_req_t;

  // string descriptor answer
  typedef struct packed {
    logic valid;
    logic supported;
    logic [6:0] length;
    logic [15:0] lang_code;
  } usdc_desc_rsp_t;

  // unique id generator phases
  typedef enum logic {
    USDC_UID_MIX,
    USDC_UID_HOLD
  } usdc_uid_state_t;
endpackage : usdc_pkg

/* src/usdc_uid_gen.sv */
// unique id source: mixes an lfsr with a synchronised entropy pin, then freezes
// assumes: entropy pin is asynchronous; one clock, active-low async reset
`timescale 1ns/1ps
`default_nettype none
`include "usdc_defines.svh"

module usdc_uid_gen #(
  parameter logic [31:0] SEED = 32'h1234abcd // arbitrary value
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic entropy_in,
  output logic [127:0] uid_out,
  output logic uid_ready_out
);
  import usdc_pkg::*;

  // elaboration check: a zero seed would lock the lfsr
  if (SEED == 32'h0)
  begin : g_bad_seed
    $error("usdc_uid_gen: zero seed locks the lfsr");
  end

  logic ent_meta;
  logic ent_sync;
  logic [31:0] lfsr;
  logic [7:0] spin;
  usdc_uid_state_t state;

  // two-flop synchroniser for the entropy pin
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      ent_meta <= 1'b0;
      ent_sync <= 1'b0;
    end
    else
    begin
      ent_meta <= entropy_in;
      ent_sync <= ent_meta;
    end
  end

  // mixing lfsr and spin counter
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      lfsr <= SEED;
      spin <= 8'h00;
      state <= USDC_UID_MIX;
    end
    else
    begin
      unique case (state)
        USDC_UID_MIX:
        begin
          lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0] ^ ent_sync};
          spin <= spin + 8'h01;
          if (spin == `USDC_UID_SPIN - 8'h01)
          begin
            state <= USDC_UID_HOLD;
          end
        end
        USDC_UID_HOLD:
        begin
          lfsr <= lfsr;
        end
      endcase
    end
  end

  // id shift register, formatted as version 4 once frozen
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      uid_out <= 128'h0;
      uid_ready_out <= 1'b0;
    end
    else if (state == USDC_UID_MIX)
    begin
      uid_out <= {uid_out[126:0], lfsr[31]}; // device-supplied bits
    end
    else if (!uid_ready_out)
    begin
      uid_out[`USDC_UID_VER_BYTE*8+4 +: 4] <= `USDC_UID_VER_NIB;
      uid_out[`USDC_UID_VAR_BYTE*8+6 +: 2] <= `USDC_UID_VAR_BITS;
      uid_ready_out <= 1'b1;
    end
  end
endmodule : usdc_uid_gen
`default_nettype wire

/* src/usdc_desc_report.sv */
// answers string descriptor queries with length and language code
// assumes: queries come from same-clock control logic
`timescale 1ns/1ps
`default_nettype none
`include "usdc_defines.svh"

module usdc_desc_report (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire usdc_pkg::usdc_desc_req_t req_in,
  input wire logic [7:0] lang_low_in,
  input wire logic [7:0] lang_high_in,
  input wire logic [5:0] ser_len_in,
  input wire logic [6:0] maker_len_in,
  output usdc_pkg::usdc_desc_rsp_t rsp_out
);
  import usdc_pkg::*;

  // one-cycle registered answer
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rsp_out <= '0;
    end
    else
    begin
      rsp_out.valid <= req_in.valid;
      rsp_out.lang_code <= {lang_high_in, lang_low_in}; // single language
      rsp_out.supported <= 1'b0;
      rsp_out.length <= 7'h00;
      if (req_in.valid)
      begin
        if (req_in.index == `USDC_IDX_LANG)
        begin
          rsp_out.supported <= 1'b1; // index 0 carries the code
          rsp_out.length <= 7'h02;
        end
        else if (req_in.index == `USDC_IDX_SERIAL)
        begin
          rsp_out.supported <= (ser_len_in != 6'h00);
          rsp_out.length <= {1'b0, ser_len_in};
        end
        else if (req_in.index == `USDC_IDX_MAKER)
        begin
          rsp_out.supported <= (maker_len_in != 7'h00); // zero hides it
          rsp_out.length <= maker_len_in;
        end
      end
    end
  end
endmodule : usdc_desc_report
`default_nettype wire

/* src/usdc_config.sv */
// descriptor identity config registers of a usb hub: unique id, language code,
// serial and maker string lengths, with conditional overwrite by eeprom/smbus
// assumes: config port and enables come from same-clock logic; entropy pin is async
//
// Contract
// - sixteen read-only id bytes at 10h-1Fh
// - the device itself supplies id bytes
// - id formatted as RFC 4122 UUID
// - low language byte returned at index 0
// - exactly one language code, low plus high
// - low language byte resets to 09h
// - high language byte resets to 04h
// - language bytes writable only when custom strings set
// - serial length bits 5:0, reset 18h
// - serial length writable only when custom serial set
// - nonzero serial length returned at index 1
// - serial length bits 7:6 read zero
// - maker length resets to zero
`timescale 1ns/1ps
`default_nettype none
`include "usdc_defines.svh"

module usdc_config #(
  parameter logic [31:0] UID_SEED = 32'h5a5a0f0f // arbitrary value
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire usdc_pkg::usdc_cfg_req_t cfg_req_in,
  input wire logic custom_strings_enable_in,
  input wire logic custom_serial_enable_in,
  input wire logic entropy_in,
  input wire usdc_pkg::usdc_desc_req_t desc_req_in,
  output usdc_pkg::usdc_cfg_rsp_t cfg_rsp_out,
  output usdc_pkg::usdc_desc_rsp_t desc_rsp_out,
  output logic [127:0] container_id_out,
  output logic container_id_ready_out
);
  import usdc_pkg::*;

  logic [7:0] language_code_low;
  logic [7:0] language_code_high;
  logic [5:0] serial_string_length;
  logic [6:0] maker_string_length;
  logic [127:0] uid;
  logic uid_ready;
  logic [7:0] next_rdata;

  // true when addr falls in the unique id range
  function automatic logic in_uid(input logic [7:0] addr);
    in_uid = (addr >= `USDC_UID_FIRST) && (addr <= `USDC_UID_LAST);
  endfunction : in_uid

  // true for a write that hits addr
  function automatic logic wr_hit(input usdc_cfg_req_t req, input logic [7:0] addr);
    wr_hit = req.wr && (req.addr == addr);
  endfunction : wr_hit

  // device-supplied unique id
  usdc_uid_gen #(
    .SEED(UID_SEED)
  ) u_uid (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .entropy_in(entropy_in),
    .uid_out(uid),
    .uid_ready_out(uid_ready)
  );

  // language code bytes, gated by custom strings enable
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      language_code_low <= `USDC_LANG_LOW_RST;
      language_code_high <= `USDC_LANG_HIGH_RST;
    end
    else if (custom_strings_enable_in) // otherwise writes dropped
    begin
      if (wr_hit(cfg_req_in, `USDC_LANG_LOW_OFS))
      begin
        language_code_low <= cfg_req_in.wdata;
      end
      if (wr_hit(cfg_req_in, `USDC_LANG_HIGH_OFS))
      begin
        language_code_high <= cfg_req_in.wdata;
      end
    end
  end

  // serial string length, gated by custom serial enable
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      serial_string_length <= `USDC_SER_LEN_RST;
    end
    else if (custom_serial_enable_in && wr_hit(cfg_req_in, `USDC_SER_LEN_OFS))
    begin
      serial_string_length <= cfg_req_in.wdata[`USDC_SER_LEN_W-1:0];
    end
  end

  // maker string length, gated by custom strings enable
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      maker_string_length <= `USDC_MAKER_LEN_RST;
    end
    else if (custom_strings_enable_in && wr_hit(cfg_req_in, `USDC_MAKER_LEN_OFS))
    begin
      maker_string_length <= cfg_req_in.wdata[`USDC_MAKER_LEN_W-1:0];
    end
  end

  // read decode; unmapped offsets read zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (in_uid(cfg_req_in.addr))
    begin
      next_rdata = uid[8*(cfg_req_in.addr[3:0]) +: 8]; // read-only id bytes
    end
    else
    begin
      unique case (cfg_req_in.addr)
        `USDC_LANG_LOW_OFS: next_rdata = language_code_low;
        `USDC_LANG_HIGH_OFS: next_rdata = language_code_high;
        `USDC_SER_LEN_OFS: next_rdata = {2'b00, serial_string_length};
        `USDC_MAKER_LEN_OFS: next_rdata = {1'b0, maker_string_length};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      cfg_rsp_out <= '0;
    end
    else
    begin
      cfg_rsp_out.valid <= cfg_req_in.rd;
      cfg_rsp_out.rdata <= cfg_req_in.rd ? next_rdata : 8'h00;
    end
  end

  // container id presented to the descriptor logic
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      container_id_out <= 128'h0;
      container_id_ready_out <= 1'b0;
    end
    else
    begin
      container_id_out <= uid;
      container_id_ready_out <= uid_ready;
    end
  end

  // string descriptor lengths and language code; loader keeps length legal
  usdc_desc_report u_report (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .req_in(desc_req_in),
    .lang_low_in(language_code_low),
    .lang_high_in(language_code_high),
    .ser_len_in(serial_string_length),
    .maker_len_in(maker_string_length),
    .rsp_out(desc_rsp_out)
  );
endmodule : usdc_config
`default_nettype wire

/* verification/usdc_config_monitor.sv */
// checker of the config slice port relations
// assumes: bound to usdc_config, one clock domain
`timescale 1ns/1ps
`default_nettype none
module usdc_config_monitor (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire usdc_pkg::usdc_cfg_req_t cfg_req_in,
  input wire logic custom_strings_enable_in,
  input wire usdc_pkg::usdc_desc_req_t desc_req_in,
  input wire usdc_pkg::usdc_cfg_rsp_t cfg_rsp_out,
  input wire usdc_pkg::usdc_desc_rsp_t desc_rsp_out,
  input wire logic [127:0] container_id_out,
  input wire logic container_id_ready_out
);
  import usdc_pkg::*;
  logic lang_wr;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // enabled write to either language byte
  assign lang_wr = cfg_req_in.wr && custom_strings_enable_in && cfg_req_in.addr[7:1] == 7'h10;
  AST_RD_LAT: assert property (cfg_req_in.rd |=> cfg_rsp_out.valid)
    else $error("read not answered");
  AST_SER_RSV: assert property (cfg_req_in.rd && cfg_req_in.addr == 8'h22
    |=> cfg_rsp_out.rdata[7:6] == 2'h0) else $error("serial length top bits set");
  AST_UID_RO: assert property (container_id_ready_out && cfg_req_in.rd
    && cfg_req_in.addr[7:4] == 4'h1
    |=> cfg_rsp_out.rdata == container_id_out[$past(cfg_req_in.addr[3:0]) * 8 +: 8])
    else $error("id byte differs from container id");
  AST_UID_STABLE: assert property ($past(container_id_ready_out)
    |-> container_id_ready_out && $stable(container_id_out)) else $error("id moved");
  AST_UID_FMT: assert property (container_id_ready_out
    |-> container_id_out[55:52] == 4'h4 && container_id_out[71:70] == 2'h2)
    else $error("id format wrong");
  AST_LANG_IDX: assert property (desc_req_in.valid && desc_req_in.index == 8'h00
    |=> desc_rsp_out.supported && desc_rsp_out.length == 7'h02) else $error("index 0");
  AST_UNSUP: assert property (desc_req_in.valid
    && !(desc_req_in.index inside {8'h00, 8'h01, 8'h03})
    |=> !desc_rsp_out.supported && desc_rsp_out.length == 7'h00) else $error("bad index");
  AST_LANG_GATE: assert property ($past(nrst_in, 2) && $changed(desc_rsp_out.lang_code)
    |-> $past(lang_wr, 2)) else $error("language code changed without write");
  // main scenarios
  COV_WR: cover property (lang_wr);
  COV_SER: cover property (desc_req_in.valid && desc_req_in.index == 8'h01);
  COV_RDY: cover property ($rose(container_id_ready_out));
endmodule : usdc_config_monitor
bind usdc_config usdc_config_monitor usdc_config_monitor_inst (.clk_in, .nrst_in,
  .cfg_req_in, .custom_strings_enable_in, .desc_req_in, .cfg_rsp_out, .desc_rsp_out,
  .container_id_out, .container_id_ready_out);
`default_nettype wire

/* verification/usdc_loader.sv */
// configuration source model: byte writes and reads on the config port
// assumes: same clock as the slice; caller waits for reset release
`timescale 1ns/1ps
`default_nettype none
module usdc_loader (
  input wire logic clk_in,
  input wire usdc_pkg::usdc_cfg_rsp_t cfg_rsp_in,
  output usdc_pkg::usdc_cfg_req_t cfg_req_out
);
  import usdc_pkg::*;
  initial cfg_req_out = '0;
  // one write strobe; serial length never above 32 bytes
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h22 && d[5:0] > 6'h20)
      d[5:0] = 6'h20;
    @(posedge clk_in);
    cfg_req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    cfg_req_out <= '0;
  endtask : put
  // one read strobe, answer taken in its single valid cycle
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    cfg_req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    cfg_req_out <= '0;
    #1;
    d = cfg_rsp_in.valid ? cfg_rsp_in.rdata : 8'hxx;
  endtask : get
endmodule : usdc_loader
`default_nettype wire

/* verification/test_usdc_config.sv */
// self-checking bench of the descriptor string config slice
// assumes: loader model drives the config port, bench drives the rest
`timescale 1ns/1ps
`default_nettype none
module test_usdc_config;
  import usdc_pkg::*;
  logic clk_in;
  logic nrst_in;
  logic str_en;
  logic ser_en;
  logic entropy = 1'b0;
  usdc_desc_req_t dq;
  usdc_cfg_req_t cq;
  usdc_cfg_rsp_t cr;
  usdc_desc_rsp_t dr;
  logic [127:0] cid;
  logic cid_rdy;
  logic [7:0] v;
  int err_count;
  int n_checks;
  usdc_config usdc_config_inst (.clk_in, .nrst_in, .cfg_req_in(cq),
    .custom_strings_enable_in(str_en), .custom_serial_enable_in(ser_en), .entropy_in(entropy),
    .desc_req_in(dq), .cfg_rsp_out(cr), .desc_rsp_out(dr), .container_id_out(cid),
    .container_id_ready_out(cid_rdy));
  usdc_loader usdc_loader_inst (.clk_in, .cfg_rsp_in(cr), .cfg_req_out(cq));
  // clock and a toggling entropy pin
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) entropy <= ~entropy;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // reads 20h..23h against four expected bytes
  task automatic regs4(input logic [31:0] e);
    for (int a = 0; a < 4; a++)
    begin
      usdc_loader_inst.get(8'h20 + a[7:0], v);
      chk($sformatf("reg %h", 8'h20 + a[7:0]), {8'h00, e[31 - 8 * a -: 8]}, {8'h00, v});
    end
  endtask : regs4
  // one descriptor query, answer seen in its valid cycle
  task automatic dsc(input logic [7:0] i, input logic s, input logic [6:0] l);
    @(posedge clk_in);
    dq <= '{valid: 1'b1, index: i};
    @(posedge clk_in);
    dq <= '{valid: 1'b0, index: ~i};
    #1;
    chk($sformatf("desc %h", i), {14'h0, 1'b1, s}, {14'h0, dr.valid, dr.supported});
    chk($sformatf("len %h", i), {9'h0, l}, {9'h0, dr.length});
  endtask : dsc
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // watchdog far beyond the expected run
  initial
  begin
    #60000;
    err_count++;
    close_out();
  end
  initial
  begin
    nrst_in = 1'b0;
    str_en = 1'b0;
    ser_en = 1'b0;
    dq = '0;
    err_count = 0;
    n_checks = 0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    regs4(32'h09041800);
    usdc_loader_inst.get(8'h05, v);
    chk("unmapped", 16'h0000, {8'h00, v});
    dsc(8'h00, 1'b1, 7'h02);
    chk("lang code", 16'h0409, dr.lang_code);
    dsc(8'h01, 1'b1, 7'h18);
    dsc(8'h03, 1'b0, 7'h00);
    dsc(8'h02, 1'b0, 7'h00);
    $display("test reset values done");
    for (int a = 0; a < 4; a++)
      usdc_loader_inst.put(8'h20 + a[7:0], 8'h11);
    regs4(32'h09041800);
    $display("test gated writes done");
    str_en <= 1'b1;
    // 23h takes f9h, its bit 7 is dropped, so the maker length reads 79h
    for (int a = 0; a < 4; a++)
      usdc_loader_inst.put(8'h20 + a[7:0], 8'h0a - 8'h02 * a[7:0] + 8'hf5 * (a == 3));
    regs4(32'h0a081879);
    dsc(8'h00, 1'b1, 7'h02);
    chk("lang code", 16'h080a, dr.lang_code);
    dsc(8'h03, 1'b1, 7'h79);
    str_en <= 1'b0;
    ser_en <= 1'b1;
    usdc_loader_inst.put(8'h22, 8'he0);
    regs4(32'h0a082079);
    dsc(8'h01, 1'b1, 7'h20);
    usdc_loader_inst.put(8'h22, 8'h00);
    dsc(8'h01, 1'b0, 7'h00);
    $display("test enabled writes done");
    nrst_in <= 1'b0;
    @(posedge clk_in);
    nrst_in <= 1'b1;
    regs4(32'h09041800);
    for (int i = 0; i < 400 && cid_rdy !== 1'b1; i++)
      @(posedge clk_in);
    chk("id ready", 16'h0001, {15'h0, cid_rdy});
    usdc_loader_inst.get(8'h18, v);
    chk("id variant", 16'h0002, {14'h0, v[7:6]});
    usdc_loader_inst.get(8'h16, v);
    chk("id version", 16'h0004, {12'h0, v[7:4]});
    chk("cid byte 6", {8'h00, cid[55:48]}, {8'h00, v});
    chk("cid version", 16'h0004, {12'h0, cid[55:52]});
    str_en <= 1'b1;
    usdc_loader_inst.put(8'h16, ~v);
    usdc_loader_inst.get(8'h16, v);
    chk("id version kept", 16'h0004, {12'h0, v[7:4]});
    $display("test unique id done");
    close_out();
  end
endmodule : test_usdc_config
`default_nettype wire
